// [rtl/tbef_pkg.sv]
// Constants, field layout and mode codes for the trace line formatter.
// Assumes one 20 MHz system clock and a 64-line trace buffer behind the formatter.
//
// Notes on behaviour
// [RULE_01] Detail mode puts address and data on two lines, so 32 entries fit.
// [RULE_02] Detail mode advances the valid-line counter twice per captured access.
// [RULE_03] Loop mode lines use exactly the normal change-of-flow line format.
// [RULE_04] Byte access data goes to the low data byte; high byte cleared.
// [RULE_05] Word access: lower-address byte to byte one, higher-address byte to byte zero.
// [RULE_06] Lines hold a 4-bit info field over two 8-bit address or data fields.
// [RULE_07] Detail info bit 3 is access size: 0 word, 1 byte.
// [RULE_08] Detail info bit 2 is direction: 0 write, 1 read.
// [RULE_09] Detail info bits 1 and 0 carry address bits 17 and 16.
// [RULE_10] Normal/loop info bit 3 flags source (0) or destination (1).
// [RULE_11] Normal/loop info bit 2 flags a vector; vectors also set destination.
// [RULE_12] Normal/loop info bits 1 and 0 carry program counter bits 17 and 16.
// [RULE_13] Compressed code 00: low 18 bits hold a full base program counter.
// [RULE_14] Compressed code 01: bits 5..0 hold one increment from base zero.
// [RULE_15] Compressed code 10: bits 11..0 hold two increments.
// [RULE_16] Compressed code 11: bits 17..0 hold three increments.
// [RULE_17] New base line when upper twelve counter bits differ from the base.
// [RULE_18] Increment is offset from lowest address of the base's 64-address range.
// [RULE_19] First buffer line always holds a base line, also after wrap-around.
// [RULE_20] After wrap, reader rebuilds flow from first base line after pointer.
// [RULE_21] Unused increment fields of a compressed line are written as zero.
// [RULE_22] Compressed mode records every executed opcode, illegal ones too.
// [RULE_23] Loop mode keeps a copy of each stored address to drop repeats; the code keeps only the last and drops repeated sources.
// [RULE_24] Readout gives fields one and zero first, then field two zero-extended.

`default_nettype none

package tbef_pkg;

	// ----------------------------------------------------------------
	// Line layout
	// ----------------------------------------------------------------
	localparam int LINE_W    = 20;
	localparam int ADDR_W    = 18;
	localparam int BYTE_W    = 8;
	localparam int INFO_W    = 4;
	localparam int INFO_LSB  = 16;
	localparam int F1_LSB    = 8;
	localparam int CODE_W    = 2;
	localparam int INC_W     = 6;
	localparam int RANGE_LSB = 6;
	localparam int WORD_W    = 16;
	localparam int IDX_W     = 6;
	localparam int CNT_W     = 7;
	localparam int ENTRY_W   = IDX_W + LINE_W;

	localparam logic [CNT_W-1:0]  NUM_LINES = 7'h40;
	localparam logic [IDX_W-1:0]  IDX_ZERO  = 6'h00;
	localparam logic [IDX_W-1:0]  IDX_ONE   = 6'h01;
	localparam logic [INC_W-1:0]  INC_ZERO  = 6'h00;

	// ----------------------------------------------------------------
	// Compressed line codes
	// ----------------------------------------------------------------
	localparam logic [CODE_W-1:0] CODE_BASE = 2'h0;
	localparam logic [CODE_W-1:0] CODE_INC1 = 2'h1;
	localparam logic [CODE_W-1:0] CODE_INC2 = 2'h2;
	localparam logic [CODE_W-1:0] CODE_INC3 = 2'h3;

	typedef enum logic [1:0] {
		MODE_NORMAL = 2'b00,
		MODE_LOOP   = 2'b01,
		MODE_DETAIL = 2'b10,
		MODE_CPC    = 2'b11
	} tbef_mode_e;

	typedef enum logic [1:0] {
		CPC_NONE = 2'b00,
		CPC_ONE  = 2'b01,
		CPC_TWO  = 2'b10
	} tbef_cpc_e;

endpackage

`default_nettype wire

// [rtl/tbef_line_counter.sv]
// Valid-line counter and write index of the trace buffer.
// Assumes add is the number of lines formed in this cycle (0 to 2).
`timescale 1ns/10ps
`default_nettype none

module tbef_line_counter
	import tbef_pkg::*;
(
	input  wire logic             clk,       // System clock
	input  wire logic             nrst,      // Synchronous reset, active low
	input  wire logic             clear,     // Session start, restarts at line zero
	input  wire logic [1:0]       add,       // Lines formed this cycle
	output logic      [IDX_W-1:0] wr_idx,    // Index of the next line
	output logic      [CNT_W-1:0] valid_cnt, // Valid lines, saturates at 64
	output logic                  wrapped    // Writing has rolled over
);

	logic [CNT_W-1:0] sum;

	assign sum = CNT_W'(wr_idx) + CNT_W'(add);

	always_ff @(posedge clk) begin
		if (!nrst || clear) begin
			wr_idx    <= IDX_ZERO;
			valid_cnt <= '0;
			wrapped   <= 1'b0;
		end else begin
			wr_idx <= sum[IDX_W-1:0];
			if (sum >= NUM_LINES)
				wrapped <= 1'b1;
			// Saturate: after rollover the buffer is simply full
			if (valid_cnt + CNT_W'(add) >= NUM_LINES)
				valid_cnt <= NUM_LINES;
			else
				valid_cnt <= valid_cnt + CNT_W'(add);
		end
	end

	a_count_bound: assert property ( // [RULE_01]
		@(posedge clk) disable iff (!nrst) valid_cnt <= NUM_LINES)
		else $error("valid line count above buffer depth");

endmodule // tbef_line_counter

`default_nettype wire

// [rtl/tbef_line_fifo.sv]
// Two-entry buffer between the formatter and the trace buffer write port.
// Assumes the consumer may hold out_ready low for any number of cycles.
`timescale 1ns/10ps
`default_nettype none

module tbef_line_fifo
	import tbef_pkg::*;
#(
	parameter int WIDTH = ENTRY_W
) (
	input  wire logic             clk,       // System clock
	input  wire logic             nrst,      // Synchronous reset, active low
	input  wire logic             in_valid,  // Entry offered
	output logic                  in_ready,  // Room for an entry
	input  wire logic [WIDTH-1:0] in_data,   // Entry contents
	output logic                  out_valid, // Entry available
	input  wire logic             out_ready, // Consumer takes the entry
	output logic      [WIDTH-1:0] out_data   // Oldest entry, from a register
);

	logic [WIDTH-1:0] mem_q [2];
	logic             wr_ptr_q;
	logic             rd_ptr_q;
	logic [1:0]       count_q;
	logic             push;
	logic             pop;

	assign in_ready  = (count_q != 2'h2);
	assign out_valid = (count_q != 2'h0);
	assign out_data  = mem_q[rd_ptr_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push)
			mem_q[wr_ptr_q] <= in_data;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			count_q  <= 2'h0;
		end else begin
			wr_ptr_q <= wr_ptr_q ^ push;
			rd_ptr_q <= rd_ptr_q ^ pop;
			count_q  <= count_q + {1'b0, push} - {1'b0, pop};
		end
	end

	a_stall_hold: assert property (
		@(posedge clk) disable iff (!nrst)
		out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("buffered line changed while stalled");

endmodule // tbef_line_fifo

`default_nettype wire

// [rtl/tbef_formatter.sv]
// Trace line formatter: builds trace buffer lines for change-of-flow, loop,
// detail and compressed program-counter modes.
// Assumes capture strobes come from core logic on clk and that the buffer
// write port drains line_valid/line_ready; session_start begins a session.
`timescale 1ns/10ps
`default_nettype none

module tbef_formatter
	import tbef_pkg::*;
(
	input  wire logic              clk,                // System clock, 20 MHz
	input  wire logic              nrst,               // Synchronous reset, active low
	input  wire logic              trace_en,           // Tracing enabled
	input  wire logic [1:0]        trace_mode_select,  // Trace mode code
	input  wire logic              session_start,      // Pulse: new session at line 0
	input  wire logic              flush_req,          // Write out pending increments
	input  wire logic              cof_valid,          // Change-of-flow address offered
	output logic                   cof_ready,          // Change-of-flow address taken
	input  wire logic [ADDR_W-1:0] cof_addr,           // Program counter to store
	input  wire logic              cof_is_dest,        // Address is a destination
	input  wire logic              cof_is_vector,      // Address is a vector
	input  wire logic              acc_valid,          // Data access offered
	output logic                   acc_ready,          // Data access taken
	input  wire logic [ADDR_W-1:0] acc_addr,           // Access address
	input  wire logic              acc_is_byte,        // Byte access, else word
	input  wire logic              acc_is_read,        // Read access, else write
	input  wire logic [BYTE_W-1:0] acc_byte_lo_addr,   // Byte at lower address
	input  wire logic [BYTE_W-1:0] acc_byte_hi_addr,   // Byte at higher address
	input  wire logic              op_valid,           // Executed opcode offered
	output logic                   op_ready,           // Executed opcode taken
	input  wire logic [ADDR_W-1:0] op_pc,              // Opcode program counter
	output logic                   line_valid,         // Line available
	input  wire logic              line_ready,         // Buffer writes the line
	output logic      [IDX_W-1:0]  line_index,         // Buffer line number
	output logic      [LINE_W-1:0] line_data,          // Full line contents
	output logic      [WORD_W-1:0] line_word_lo,       // First readout word
	output logic      [WORD_W-1:0] line_word_hi,       // Second readout word
	output logic      [CNT_W-1:0]  valid_line_counter, // Valid lines in buffer
	output logic                   buffer_wrapped,     // Writing rolled over
	output logic                   cpc_pending         // Increments held back
);

	// ----------------------------------------------------------------
	// Line builders
	// ----------------------------------------------------------------
	function automatic logic [LINE_W-1:0] base_line(input logic [ADDR_W-1:0] pc);
		base_line = {CODE_BASE, pc}; // [RULE_13]
	endfunction

	function automatic logic [LINE_W-1:0] inc_line(
		input logic [CODE_W-1:0] code,
		input logic [INC_W-1:0]  i2,
		input logic [INC_W-1:0]  i1,
		input logic [INC_W-1:0]  i0
	);
		inc_line = {code, i2, i1, i0};
	endfunction

	// Pending increments as a line; unused fields are zero
	function automatic logic [LINE_W-1:0] pend_line(
		input tbef_cpc_e        cnt,
		input logic [INC_W-1:0] i1,
		input logic [INC_W-1:0] i0
	);
		if (cnt == CPC_TWO)
			pend_line = inc_line(CODE_INC2, INC_ZERO, i1, i0); // [RULE_15] [RULE_21]
		else
			pend_line = inc_line(CODE_INC1, INC_ZERO, INC_ZERO, i0); // [RULE_14] [RULE_21]
	endfunction

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	tbef_mode_e          mode;
	logic [LINE_W-1:0]   stg_line_q [2];
	logic [IDX_W-1:0]    stg_idx_q  [2];
	logic [1:0]          stg_vld_q;
	logic                push;
	logic                room;
	logic [1:0]          n_lines;
	logic [LINE_W-1:0]   new0;
	logic [LINE_W-1:0]   new1;
	logic [IDX_W-1:0]    wr_idx;
	logic                fifo_in_ready;
	logic [ENTRY_W-1:0]  fifo_out;
	logic                cpc_act;
	logic                cof_act;
	logic                fixup;
	logic                flush_act;
	logic                need_base;
	logic                cof_fire;
	logic                acc_fire;
	logic                op_fire;
	logic                dup;
	logic [ADDR_W-RANGE_LSB-1:0] base_q;
	logic [ADDR_W-RANGE_LSB-1:0] base_d;
	logic                base_vld_q;
	logic                base_vld_d;
	tbef_cpc_e           pend_q;
	tbef_cpc_e           pend_d;
	logic [INC_W-1:0]    inc0_q;
	logic [INC_W-1:0]    inc0_d;
	logic [INC_W-1:0]    inc1_q;
	logic [INC_W-1:0]    inc1_d;
	logic [ADDR_W-1:0]   last_q;
	logic                last_vld_q;

	// ----------------------------------------------------------------
	// Acceptance
	// ----------------------------------------------------------------
	assign mode = tbef_mode_e'(trace_mode_select);
	assign push = stg_vld_q[0] && fifo_in_ready;
	// An event may form two lines, so slot 1 must be free and slot 0 free or pushed this cycle
	assign room = !stg_vld_q[1] && (!stg_vld_q[0] || push) && !session_start;

	assign cpc_act = trace_en && (mode == MODE_CPC);
	assign cof_act = trace_en && ((mode == MODE_NORMAL) || (mode == MODE_LOOP)); // [RULE_03]

	// Pending increments may not land on line zero: the oldest is restated
	// as a base line first, so line zero is always a base
	assign fixup     = cpc_act && room && (wr_idx == IDX_ZERO) && (pend_q != CPC_NONE); // [RULE_19] [RULE_20]
	assign flush_act = cpc_act && room && !fixup && flush_req && (pend_q != CPC_NONE);

	assign cof_ready = cof_act && room;
	assign acc_ready = trace_en && (mode == MODE_DETAIL) && room;
	assign op_ready  = cpc_act && room && !fixup && !flush_act; // [RULE_22]

	assign cof_fire = cof_valid && cof_ready;
	assign acc_fire = acc_valid && acc_ready;
	assign op_fire  = op_valid && op_ready;

	assign need_base = !base_vld_q || (op_pc[ADDR_W-1:RANGE_LSB] != base_q) // [RULE_17]
		|| (wr_idx == IDX_ZERO); // [RULE_19]

	// Only repeated sources are dropped; repeated destinations hint at bugs
	assign dup = (mode == MODE_LOOP) && !cof_is_dest && !cof_is_vector
		&& last_vld_q && (cof_addr == last_q); // [RULE_23]

	// ----------------------------------------------------------------
	// Line formation
	// ----------------------------------------------------------------
	always_comb begin
		n_lines    = 2'h0;
		new0       = '0;
		new1       = '0;
		base_d     = base_q;
		base_vld_d = base_vld_q;
		pend_d     = pend_q;
		inc0_d     = inc0_q;
		inc1_d     = inc1_q;
		if (fixup) begin
			// Oldest pending opcode becomes the base of line zero
			new0    = base_line({base_q, inc0_q}); // [RULE_19]
			n_lines = 2'h1;
			inc0_d  = inc1_q;
			pend_d  = (pend_q == CPC_TWO) ? CPC_ONE : CPC_NONE;
		end else if (flush_act) begin
			new0    = pend_line(pend_q, inc1_q, inc0_q);
			n_lines = 2'h1;
			pend_d  = CPC_NONE;
		end else if (op_fire) begin
			if (need_base) begin
				base_d     = op_pc[ADDR_W-1:RANGE_LSB]; // [RULE_17]
				base_vld_d = 1'b1;
				pend_d     = CPC_NONE;
				if (pend_q != CPC_NONE) begin
					new0    = pend_line(pend_q, inc1_q, inc0_q);
					new1    = base_line(op_pc);
					n_lines = 2'h2;
				end else begin
					new0    = base_line(op_pc); // [RULE_13]
					n_lines = 2'h1;
				end
			end else begin
				// Low bits are the offset from the base range's zero value
				case (pend_q)
					CPC_NONE: begin
						inc0_d = op_pc[INC_W-1:0]; // [RULE_18]
						pend_d = CPC_ONE;
					end
					CPC_ONE: begin
						inc1_d = op_pc[INC_W-1:0]; // [RULE_18]
						pend_d = CPC_TWO;
					end
					CPC_TWO: begin
						new0    = inc_line(CODE_INC3, op_pc[INC_W-1:0], inc1_q, inc0_q); // [RULE_16]
						n_lines = 2'h1;
						pend_d  = CPC_NONE;
					end
					default: begin
						pend_d = CPC_NONE;
					end
				endcase
			end
		end else if (cof_fire) begin
			if (!dup) begin
				// Vectors are destinations, so the vector flag forces the other
				new0 = {cof_is_dest || cof_is_vector, cof_is_vector, // [RULE_10] [RULE_11]
					cof_addr}; // [RULE_12] [RULE_06]
				n_lines = 2'h1;
			end
		end else if (acc_fire) begin
			new0 = {acc_is_byte, acc_is_read, acc_addr}; // [RULE_07] [RULE_08] [RULE_09]
			if (acc_is_byte)
				new1 = {INFO_W'(0), BYTE_W'(0), acc_byte_lo_addr}; // [RULE_04]
			else
				new1 = {INFO_W'(0), acc_byte_lo_addr, acc_byte_hi_addr}; // [RULE_05]
			n_lines = 2'h2; // [RULE_01] [RULE_02]
		end
	end

	// ----------------------------------------------------------------
	// Staging slots
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst || session_start) begin
			stg_vld_q <= 2'b00;
		end else if (n_lines != 2'h0) begin
			stg_vld_q <= (n_lines == 2'h2) ? 2'b11 : 2'b01;
		end else if (push) begin
			stg_vld_q <= {1'b0, stg_vld_q[1]};
		end
	end

	always_ff @(posedge clk) begin
		if (n_lines != 2'h0) begin
			stg_line_q[0] <= new0;
			stg_idx_q[0]  <= wr_idx;
			stg_line_q[1] <= new1;
			stg_idx_q[1]  <= wr_idx + IDX_ONE;
		end else if (push) begin
			stg_line_q[0] <= stg_line_q[1];
			stg_idx_q[0]  <= stg_idx_q[1];
		end
	end

	// ----------------------------------------------------------------
	// Compressed and loop state
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst || session_start) begin
			base_q     <= '0;
			base_vld_q <= 1'b0;
			pend_q     <= CPC_NONE;
			inc0_q     <= INC_ZERO;
			inc1_q     <= INC_ZERO;
		end else begin
			base_q     <= base_d;
			base_vld_q <= base_vld_d;
			pend_q     <= pend_d;
			inc0_q     <= inc0_d;
			inc1_q     <= inc1_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst || session_start) begin
			last_q     <= '0;
			last_vld_q <= 1'b0;
		end else if (cof_fire && !dup) begin
			last_q     <= cof_addr; // [RULE_23]
			last_vld_q <= 1'b1;
		end
	end

	assign cpc_pending = (pend_q != CPC_NONE);

	// ----------------------------------------------------------------
	// Counter and output buffer
	// ----------------------------------------------------------------
	tbef_line_counter tbef_line_counter_inst (
		.clk       (clk),
		.nrst      (nrst),
		.clear     (session_start),
		.add       (n_lines),          // [RULE_02]
		.wr_idx    (wr_idx),
		.valid_cnt (valid_line_counter),
		.wrapped   (buffer_wrapped)
	);

	tbef_line_fifo #(
		.WIDTH (ENTRY_W)
	) tbef_line_fifo_inst (
		.clk       (clk),
		.nrst      (nrst),
		.in_valid  (stg_vld_q[0]),
		.in_ready  (fifo_in_ready),
		.in_data   ({stg_idx_q[0], stg_line_q[0]}),
		.out_valid (line_valid),
		.out_ready (line_ready),
		.out_data  (fifo_out)
	);

	assign line_index   = fifo_out[ENTRY_W-1:LINE_W];
	assign line_data    = fifo_out[LINE_W-1:0];
	assign line_word_lo = fifo_out[WORD_W-1:0]; // [RULE_24]
	assign line_word_hi = {(WORD_W-INFO_W)'(0), fifo_out[INFO_LSB +: INFO_W]}; // [RULE_24]

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_detail_count: assert property ( // [RULE_02]
		@(posedge clk) disable iff (!nrst)
		acc_fire |=> wr_idx == $past(wr_idx) + IDX_ONE + IDX_ONE)
		else $error("detail access did not take two lines");

	a_byte_high_zero: assert property ( // [RULE_04]
		@(posedge clk) disable iff (!nrst)
		acc_fire && acc_is_byte |=> stg_vld_q == 2'b11
			&& stg_line_q[1][F1_LSB +: BYTE_W] == BYTE_W'(0)
			&& stg_line_q[1][BYTE_W-1:0] == $past(acc_byte_lo_addr))
		else $error("byte access data misplaced");

	a_word_order: assert property ( // [RULE_05]
		@(posedge clk) disable iff (!nrst)
		acc_fire && !acc_is_byte |=> stg_line_q[1][F1_LSB +: BYTE_W] == $past(acc_byte_lo_addr)
			&& stg_line_q[1][BYTE_W-1:0] == $past(acc_byte_hi_addr))
		else $error("word access byte order wrong");

	a_detail_info: assert property ( // [RULE_07]
		@(posedge clk) disable iff (!nrst)
		acc_fire |=> stg_line_q[0][INFO_LSB +: INFO_W]
			== {$past(acc_is_byte), $past(acc_is_read), $past(acc_addr[ADDR_W-1:INFO_LSB])})
		else $error("detail info bits wrong");

	a_vector_dest: assert property ( // [RULE_11]
		@(posedge clk) disable iff (!nrst)
		cof_fire && cof_is_vector |=> stg_vld_q[0]
			&& stg_line_q[0][LINE_W-1 -: 2] == 2'b11)
		else $error("vector line lacks destination flag");

	a_loop_filter: assert property ( // [RULE_23]
		@(posedge clk) disable iff (!nrst)
		cof_fire && dup |=> wr_idx == $past(wr_idx))
		else $error("duplicate source stored in loop mode");

	a_first_base: assert property ( // [RULE_19]
		@(posedge clk) disable iff (!nrst)
		cpc_act && n_lines != 2'h0 && wr_idx == IDX_ZERO
			|-> new0[ADDR_W +: CODE_W] == CODE_BASE)
		else $error("line zero is not a base line");

	a_unused_zero: assert property ( // [RULE_21]
		@(posedge clk) disable iff (!nrst)
		cpc_act && n_lines != 2'h0 && new0[ADDR_W +: CODE_W] == CODE_INC1
			|-> new0[ADDR_W-1:INC_W] == '0)
		else $error("unused increment field not zero");

	a_range_base: assert property ( // [RULE_17]
		@(posedge clk) disable iff (!nrst)
		op_fire && base_vld_q && op_pc[ADDR_W-1:RANGE_LSB] != base_q
			|=> base_q == $past(op_pc[ADDR_W-1:RANGE_LSB]) && pend_q == CPC_NONE)
		else $error("range change did not start a new base");

endmodule // tbef_formatter

`default_nettype wire

// [tb/tbef_sink_model.sv]
// Trace buffer write port model: takes formatted lines, can stall.
// Assumes lines arrive on clk and stand until taken.
`timescale 1ns/10ps
`default_nettype none

module tbef_sink_model
	import tbef_pkg::*;
(
	input  wire logic              clk,        // System clock
	input  wire logic              stall,      // Hold off the formatter
	input  wire logic              line_valid, // Line offered
	output logic                   line_ready, // Line taken
	input  wire logic [IDX_W-1:0]  line_index, // Buffer line number
	input  wire logic [LINE_W-1:0] line_data   // Line contents
);
	logic [ENTRY_W-1:0] got[$];

	assign line_ready = !stall;

	// Keep every taken line in arrival order for the bench
	always @(posedge clk) begin
		if (line_valid && line_ready) begin
			got.push_back({line_index, line_data});
		end
	end
endmodule // tbef_sink_model

`default_nettype wire

// [tb/tbef_formatter_tb_top.sv]
// Self-checking bench for the trace line formatter.
// Assumes the sink model as buffer write port; one 20 MHz clock.
`timescale 1ns/10ps
`default_nettype none

module tbef_formatter_tb_top
	import tbef_pkg::*;
();
	logic clk, nrst, trace_en, session_start, flush_req, stall;
	logic cof_valid, cof_ready, cof_is_dest, cof_is_vector, acc_valid, acc_ready;
	logic acc_is_byte, acc_is_read, op_valid, op_ready, line_valid, line_ready;
	logic [1:0] mode;
	logic [ADDR_W-1:0] cof_addr, acc_addr, op_pc;
	logic [BYTE_W-1:0] blo, bhi;
	logic [IDX_W-1:0] line_index;
	logic [LINE_W-1:0] line_data;
	logic [WORD_W-1:0] wlo, whi;
	logic [CNT_W-1:0] vcnt;
	logic wrapped, cpc_pend;
	int mismatches, checks_done;

	tbef_formatter tbef_formatter_inst (.clk(clk), .nrst(nrst), .trace_en(trace_en),
		.trace_mode_select(mode), .session_start(session_start), .flush_req(flush_req),
		.cof_valid(cof_valid), .cof_ready(cof_ready), .cof_addr(cof_addr),
		.cof_is_dest(cof_is_dest), .cof_is_vector(cof_is_vector), .acc_valid(acc_valid),
		.acc_ready(acc_ready), .acc_addr(acc_addr), .acc_is_byte(acc_is_byte),
		.acc_is_read(acc_is_read), .acc_byte_lo_addr(blo), .acc_byte_hi_addr(bhi),
		.op_valid(op_valid), .op_ready(op_ready), .op_pc(op_pc), .line_valid(line_valid),
		.line_ready(line_ready), .line_index(line_index), .line_data(line_data),
		.line_word_lo(wlo), .line_word_hi(whi), .valid_line_counter(vcnt),
		.buffer_wrapped(wrapped), .cpc_pending(cpc_pend));

	tbef_sink_model tbef_sink_model_inst (.clk(clk), .stall(stall), .line_valid(line_valid),
		.line_ready(line_ready), .line_index(line_index), .line_data(line_data));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(string what, logic [WORD_W-1:0] exp, logic [WORD_W-1:0] got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_line(logic [IDX_W-1:0] idx, logic [LINE_W-1:0] exp);
		int i;
		logic [ENTRY_W-1:0] got;
		for (i = 0; i < 40 && tbef_sink_model_inst.got.size() == 0; i++) begin
			@(posedge clk);
			#1;
		end
		if (i == 40) begin
			mismatches++;
			summarize();
		end
		got = tbef_sink_model_inst.got.pop_front();
		checks_done++;
		if (got !== {idx, exp}) begin
			mismatches++;
			$display("BAD line expected %h seen %h", {idx, exp}, got);
		end
	endtask

	// Holds the request until the ready of family f is seen at a falling edge, then past the next rising edge
	task automatic hs(int f);
		int i;
		i = 0;
		do @(negedge clk);
		while (((f == 0) ? cof_ready : (f == 1) ? acc_ready : op_ready) !== 1'b1 && ++i < 40);
		if (i == 40) begin
			mismatches++;
			summarize();
		end
		@(posedge clk);
		#1;
	endtask

	task automatic session(logic [1:0] m);
		mode = m;
		session_start = 1'b1;
		@(posedge clk);
		#1;
		session_start = 1'b0;
	endtask

	task automatic cof(logic [ADDR_W-1:0] a, logic d, logic v);
		cof_valid = 1'b1;
		cof_addr = a;
		cof_is_dest = d;
		cof_is_vector = v;
		hs(0);
	endtask

	task automatic acc(logic [ADDR_W-1:0] a, logic b, logic r, logic [7:0] lo, logic [7:0] hi);
		acc_valid = 1'b1;
		acc_addr = a;
		acc_is_byte = b;
		acc_is_read = r;
		blo = lo;
		bhi = hi;
		hs(1);
	endtask

	task automatic op(logic [ADDR_W-1:0] pc);
		op_valid = 1'b1;
		op_pc = pc;
		hs(2);
	endtask

	task automatic t_normal();
		session(MODE_NORMAL);
		cof(18'h12345, 1'b0, 1'b0);
		cof(18'h3FFF2, 1'b1, 1'b1);
		cof(18'h2ABCD, 1'b1, 1'b0);
		cof_valid = 1'b0;
		chk_line(6'h00, 20'h12345);
		chk_line(6'h01, 20'hFFFF2);
		chk_line(6'h02, 20'hAABCD);
		$display("normal mode done");
	endtask

	task automatic t_loop();
		session(MODE_LOOP);
		cof(18'h00400, 1'b0, 1'b0);
		cof(18'h00400, 1'b0, 1'b0);
		cof(18'h00500, 1'b1, 1'b0);
		cof(18'h00500, 1'b1, 1'b0);
		cof_valid = 1'b0;
		chk_line(6'h00, 20'h00400);
		chk_line(6'h01, 20'h80500);
		chk_line(6'h02, 20'h80500);
		chk("count", 16'h0003, {9'h000, vcnt});
		$display("loop mode done");
	endtask

	task automatic t_detail();
		session(MODE_DETAIL);
		stall = 1'b1;
		acc(18'h2ABCD, 1'b0, 1'b1, 8'h11, 8'h22);
		acc(18'h00010, 1'b1, 1'b0, 8'h5A, 8'hC3);
		acc_valid = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		chk("word lo", 16'hABCD, wlo);
		chk("word hi", 16'h0006, whi);
		stall = 1'b0;
		chk_line(6'h00, 20'h6ABCD);
		chk_line(6'h01, 20'h01122);
		chk_line(6'h02, 20'h80010);
		chk_line(6'h03, 20'h0005A);
		chk("count", 16'h0004, {9'h000, vcnt});
		$display("detail mode done");
	endtask

	task automatic t_cpc();
		session(MODE_CPC);
		op(18'h00100);
		op(18'h00103);
		op(18'h00105);
		op(18'h00107);
		op(18'h00108);
		op(18'h00250);
		op(18'h00251);
		op(18'h00252);
		op(18'h00300);
		op_valid = 1'b0;
		chk_line(6'h00, 20'h00100);
		chk_line(6'h01, 20'hC7143);
		chk_line(6'h02, 20'h40008);
		chk_line(6'h03, 20'h00250);
		chk_line(6'h04, 20'h80491);
		chk_line(6'h05, 20'h00300);
		$display("compressed mode done");
	endtask

	// Continues the compressed session: flush, then fill past line 63
	task automatic t_wrap();
		int k;
		op(18'h00305);
		op_valid = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("pending", 16'h0001, {15'h0000, cpc_pend});
		flush_req = 1'b1;
		@(posedge clk);
		#1;
		flush_req = 1'b0;
		chk_line(6'h06, 20'h40005);
		chk("pending", 16'h0000, {15'h0000, cpc_pend});
		for (k = 7; k < 64; k++) begin
			op(18'(k) << 6);
			op_valid = 1'b0;
			chk_line(6'(k), {2'b00, 18'(k) << 6});
		end
		op(18'h00FC1);
		op_valid = 1'b0;
		chk_line(6'h00, 20'h00FC1);
		chk("wrapped", 16'h0001, {15'h0000, wrapped});
		chk("count", 16'h0040, {9'h000, vcnt});
		$display("wrap-around done");
	endtask

	initial begin
		{nrst, session_start, flush_req, stall, cof_valid, acc_valid, op_valid} = '0;
		{cof_is_dest, cof_is_vector, acc_is_byte, acc_is_read} = '0;
		{cof_addr, acc_addr, op_pc, blo, bhi} = '0;
		trace_en = 1'b1;
		mode = MODE_NORMAL;
		mismatches = 0;
		checks_done = 0;
		repeat (16) @(posedge clk);
		#1;
		nrst = 1'b1;
		t_normal();
		t_loop();
		t_detail();
		t_cpc();
		t_wrap();
		summarize();
	end
endmodule // tbef_formatter_tb_top

`default_nettype wire
